// *** design/limit_window.sv ***
// module: range compare of one position against the limit pair
`timescale 1ns/1ns
`default_nettype none
module limit_window (
    // limits
    input wire logic signed [soft_limit_pkg::POS_W-1:0] posLimit,
    input wire logic signed [soft_limit_pkg::POS_W-1:0] negLimit,
    // position under test
    input wire logic signed [soft_limit_pkg::POS_W-1:0] position,
    // results
    output logic aboveLimit,
    output logic belowLimit,
    output logic limitsZero
);
    // compares are purely combinational
    assign aboveLimit = position > posLimit;
    assign belowLimit = position < negLimit;
    assign limitsZero = (posLimit == soft_limit_pkg::POS_ZERO)
                     && (negLimit == soft_limit_pkg::POS_ZERO);
endmodule : limit_window
`default_nettype wire

// *** design/soft_position_limit_checker.sv ***
// module: software position limit supervisor for one motion axis
//
// How it works
// - checking is off when soft limit enable is 0 and, when 1, runs only once the axis is homed.
// - the live enable takes the saved value on the first clock after reset, or the factory 0 when nothing is saved.
// - the enable may be written by immediate commands, while a running sequence can only read it.
// - limits are enforced only after an electrical home return or a home seek either way finished.
// - a range violation stops the motor and, per alarm action, raises alarm 67h and cuts current.
// - overtravel stop action picks a soft deceleration or a hard stop for the violation.
// - checking is suspended for as long as any homing operation runs.
// - when homing ends and position 0 is outside the limits an alarm may be raised.
// - index targets are checked before start; bad ones do not move, absolute ones also alarm.
// - continuous moves trip only when the position crosses a limit and may start outside them.
// - after an alarm clears only homing, in-range index targets and continuous moves not heading further out are taken.
// - limits both at 0 keep checking off even when the enable is 1.
// - each status bit reads 0 when inactive and 1 when active, driven pins or not.
`timescale 1ns/1ns
`default_nettype none
module soft_position_limit_checker (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // parameter store
    input wire logic savedValid,
    input wire logic savedEnable,
    input wire logic paramWrite,
    input wire logic paramWriteData,
    input wire logic seqRunning,
    output logic pendingEnable,
    output logic softLimitEnable,
    // configuration
    input wire logic signed [soft_limit_pkg::POS_W-1:0] positivePositionLimit,
    input wire logic signed [soft_limit_pkg::POS_W-1:0] negativePositionLimit,
    input wire logic overtravelStopAction,
    input wire logic [1:0] alarmAction,
    // motion requests and feedback
    input wire logic reqValid,
    input wire soft_limit_pkg::move_req_s req,
    input wire logic signed [soft_limit_pkg::POS_W-1:0] commandedPosition,
    input wire logic motionDone,
    input wire logic alarmClear,
    // outputs to driver
    output logic startMotion,
    output logic reqRejected,
    output soft_limit_pkg::stop_cmd_s stopCmd,
    output logic alarm,
    output logic [7:0] alarmCode,
    output logic [soft_limit_pkg::SIG_W-1:0] signalStatus
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    soft_limit_pkg::move_state_e state, next_state;
    logic homed;
    logic contDirPos;
    logic signed [soft_limit_pkg::POS_W-1:0] target;
    logic startUp;
    logic tgtAbove, tgtBelow, curAbove, curBelow, limZero, zeroAbove, zeroBelow;

    // ------------------------------------------------------------
    // compares
    // ------------------------------------------------------------
    assign target = req.absMove ? req.value : commandedPosition + req.value;
    limit_window uTarget (.posLimit(positivePositionLimit), .negLimit(negativePositionLimit),
        .position(target), .aboveLimit(tgtAbove), .belowLimit(tgtBelow), .limitsZero(limZero));
    limit_window uCurrent (.posLimit(positivePositionLimit), .negLimit(negativePositionLimit),
        .position(commandedPosition), .aboveLimit(curAbove), .belowLimit(curBelow),
        .limitsZero());
    limit_window uZero (.posLimit(positivePositionLimit), .negLimit(negativePositionLimit),
        .position(soft_limit_pkg::POS_ZERO), .aboveLimit(zeroAbove), .belowLimit(zeroBelow),
        .limitsZero());

    // checking active only when enabled, homed, not homing, limits set
    logic checkActive;
    assign checkActive = softLimitEnable && homed && !limZero
                      && (state != soft_limit_pkg::MV_HOME);

    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------
    logic isIndex, isCont, isHome, idxBad, contBad, acceptReq, homeEnd, zeroBad, contTrip;
    assign isIndex = req.absMove || req.incMove;
    assign isCont = req.contPos || req.contNeg;
    assign isHome = req.homeElec || req.homePos || req.homeNeg;
    assign idxBad = checkActive && (tgtAbove || tgtBelow);
    // a continuous move outside the range must head back inward
    assign contBad = checkActive && ((req.contPos && curAbove)
                  || (req.contNeg && curBelow));
    assign acceptReq = reqValid && (state == soft_limit_pkg::MV_IDLE) && !alarm
                    && (isHome || (isIndex && !idxBad) || (isCont && !contBad));
    assign homeEnd = (state == soft_limit_pkg::MV_HOME) && motionDone;
    assign zeroBad = softLimitEnable && !limZero && (zeroAbove || zeroBelow);
    // trip only on the crossing: still heading outward
    assign contTrip = checkActive && (state == soft_limit_pkg::MV_CONT)
                   && ((contDirPos && curAbove) || (!contDirPos && curBelow));

    logic violation, idxAlarmBad, raiseAlarm, alarmWanted;
    assign idxAlarmBad = reqValid && (state == soft_limit_pkg::MV_IDLE) && !alarm
                      && req.absMove && idxBad;
    assign violation = contTrip || (homeEnd && zeroBad) || idxAlarmBad;
    assign alarmWanted = alarmAction != soft_limit_pkg::ALM_STOP_ONLY;
    assign raiseAlarm = violation && alarmWanted;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            soft_limit_pkg::MV_IDLE: begin
                if (acceptReq && isHome) next_state = soft_limit_pkg::MV_HOME;
                else if (acceptReq && isIndex) next_state = soft_limit_pkg::MV_INDEX;
                else if (acceptReq) next_state = soft_limit_pkg::MV_CONT;
            end
            soft_limit_pkg::MV_HOME: if (motionDone) next_state = soft_limit_pkg::MV_IDLE;
            soft_limit_pkg::MV_INDEX: if (motionDone) next_state = soft_limit_pkg::MV_IDLE;
            soft_limit_pkg::MV_CONT: begin
                if (contTrip || motionDone) next_state = soft_limit_pkg::MV_IDLE;
            end
            default: next_state = soft_limit_pkg::MV_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // state, homed flag and continuous direction
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= soft_limit_pkg::MV_IDLE;
            homed <= 1'b0;
            contDirPos <= 1'b0;
        end else begin
            state <= next_state;
            if (homeEnd) homed <= 1'b1;
            if (acceptReq && isCont) contDirPos <= req.contPos;
        end
    end

    // live enable loaded once after reset release, pending value from immediate writes
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            startUp <= 1'b1;
            softLimitEnable <= soft_limit_pkg::SLE_FACTORY;
            pendingEnable <= soft_limit_pkg::SLE_FACTORY;
        end else begin
            startUp <= 1'b0;
            if (startUp) begin
                softLimitEnable <= savedValid ? savedEnable : soft_limit_pkg::SLE_FACTORY;
                pendingEnable <= savedValid ? savedEnable : soft_limit_pkg::SLE_FACTORY;
            end else if (paramWrite && !seqRunning) begin
                pendingEnable <= paramWriteData;
            end
        end
    end

    // alarm latch: a new violation wins over a clear
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            alarm <= 1'b0;
            alarmCode <= 8'h00;
        end else if (raiseAlarm) begin
            alarm <= 1'b1;
            alarmCode <= soft_limit_pkg::ALARM_CODE_LIMIT;
        end else if (alarmClear) begin
            alarm <= 1'b0;
            alarmCode <= 8'h00;
        end
    end

    // stop orders and handshake pulses
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            stopCmd <= '0;
            startMotion <= 1'b0;
            reqRejected <= 1'b0;
        end else begin
            startMotion <= acceptReq;
            reqRejected <= reqValid && !acceptReq;
            stopCmd.hardStop <= (contTrip || (homeEnd && zeroBad))
                             && (overtravelStopAction == soft_limit_pkg::OT_HARD);
            stopCmd.softStop <= (contTrip || (homeEnd && zeroBad))
                             && (overtravelStopAction == soft_limit_pkg::OT_SOFT);
            if (raiseAlarm && alarmAction == soft_limit_pkg::ALM_ALARM_OFF)
                stopCmd.currentOff <= 1'b1;
            else if (alarmClear)
                stopCmd.currentOff <= 1'b0;
        end
    end

    // status bits, 1 when active
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            signalStatus <= '0;
        end else begin
            signalStatus[soft_limit_pkg::SIG_ALARM] <= alarm;
            signalStatus[soft_limit_pkg::SIG_HOMED] <= homed;
            signalStatus[soft_limit_pkg::SIG_MOVE] <= state != soft_limit_pkg::MV_IDLE;
            signalStatus[soft_limit_pkg::SIG_ACTIVE] <= checkActive;
            signalStatus[soft_limit_pkg::SIG_CUROFF] <= stopCmd.currentOff;
            signalStatus[soft_limit_pkg::SIG_STOP] <= stopCmd.hardStop || stopCmd.softStop;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_homed_gate: assert property (@(posedge mclk) disable iff (sys_rst)
        reqValid && isIndex && !homed && !alarm && state == soft_limit_pkg::MV_IDLE
        |=> startMotion) else $error("index refused before homing");
    a_home_suspend: assert property (@(posedge mclk) disable iff (sys_rst)
        state == soft_limit_pkg::MV_HOME |-> !checkActive) else $error("check while homing");
    a_zero_limits: assert property (@(posedge mclk) disable iff (sys_rst)
        limZero |-> !checkActive) else $error("check with zero limits");
    a_bad_index: assert property (@(posedge mclk) disable iff (sys_rst)
        reqValid && isIndex && idxBad |=> !startMotion) else $error("bad index started");
    a_abs_alarm: assert property (@(posedge mclk) disable iff (sys_rst)
        idxAlarmBad && alarmWanted |=> alarm && alarmCode == soft_limit_pkg::ALARM_CODE_LIMIT)
        else $error("absolute reject no alarm");
    a_trip_stop: assert property (@(posedge mclk) disable iff (sys_rst)
        contTrip |=> (stopCmd.hardStop ^ stopCmd.softStop) && state == soft_limit_pkg::MV_IDLE)
        else $error("trip without stop");
    a_seq_write: assert property (@(posedge mclk) disable iff (sys_rst)
        !startUp && seqRunning |=> $stable(pendingEnable)) else $error("sequence wrote enable");
    a_enable_fixed: assert property (@(posedge mclk) disable iff (sys_rst)
        !startUp |=> $stable(softLimitEnable)) else $error("live enable changed");
    a_homed_set: assert property (@(posedge mclk) disable iff (sys_rst)
        homeEnd |=> homed) else $error("homed not set");
    a_status_alarm: assert property (@(posedge mclk) disable iff (sys_rst)
        alarm |=> signalStatus[soft_limit_pkg::SIG_ALARM]) else $error("status mismatch");
    c_cont_trip: cover property (@(posedge mclk) disable iff (sys_rst) contTrip);
    c_index_reject: cover property (@(posedge mclk) disable iff (sys_rst) idxAlarmBad);
    c_home_done: cover property (@(posedge mclk) disable iff (sys_rst) homeEnd && zeroBad);
    c_inward: cover property (@(posedge mclk) disable iff (sys_rst)
        acceptReq && isCont && checkActive && (curAbove || curBelow));
endmodule : soft_position_limit_checker
`default_nettype wire

// *** shared/soft_limit_pkg.sv ***
// package: constants and carrier types for the software position limit checker
`default_nettype none
package soft_limit_pkg;
    localparam int POS_W = 32;
    localparam logic SLE_FACTORY = 1'h0;
    localparam logic [7:0] ALARM_CODE_LIMIT = 8'h67;
    localparam logic [POS_W-1:0] POS_ZERO = 32'h0000_0000;
    localparam logic [1:0] ALM_STOP_ONLY = 2'h0;
    localparam logic [1:0] ALM_ALARM = 2'h1;
    localparam logic [1:0] ALM_ALARM_OFF = 2'h2;
    localparam logic OT_HARD = 1'h0;
    localparam logic OT_SOFT = 1'h1;
    localparam int SIG_W = 6;
    localparam int SIG_ALARM = 0;
    localparam int SIG_HOMED = 1;
    localparam int SIG_MOVE = 2;
    localparam int SIG_ACTIVE = 3;
    localparam int SIG_CUROFF = 4;
    localparam int SIG_STOP = 5;

    typedef enum logic [3:0] {
        MV_IDLE = 4'h1,
        MV_HOME = 4'h2,
        MV_INDEX = 4'h4,
        MV_CONT = 4'h8
    } move_state_e;

    // one motion request from the command side
    typedef struct packed {
        logic absMove;
        logic incMove;
        logic contPos;
        logic contNeg;
        logic homeElec;
        logic homePos;
        logic homeNeg;
        logic signed [POS_W-1:0] value;
    } move_req_s;

    // stop order towards the motor driver
    typedef struct packed {
        logic hardStop;
        logic softStop;
        logic currentOff;
    } stop_cmd_s;
endpackage : soft_limit_pkg
`default_nettype wire

// *** sim/motor_driver_model.sv ***
// motor driver model: runs index, homing and continuous moves on command
`timescale 1ns/1ns
`default_nettype none
module motor_driver_model #(
    parameter int DLY = 4
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // commands from the checker side
    input wire logic reqValid,
    input wire soft_limit_pkg::move_req_s req,
    input wire logic startMotion,
    input wire soft_limit_pkg::stop_cmd_s stopCmd,
    // feedback
    output logic signed [31:0] commandedPosition,
    output logic motionDone
);
    // -----------------------------------------
    // motion engine
    // -----------------------------------------
    soft_limit_pkg::move_req_s held;
    logic running;
    logic halted;
    logic signed [31:0] tgt;
    int cnt;
    wire logic cont = held.contPos | held.contNeg;
    // continuous moves step one count a cycle until told to stop
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            commandedPosition <= 32'h0;
            motionDone <= 1'b0;
            running <= 1'b0;
            halted <= 1'b0;
            held <= '0;
            tgt <= 32'h0;
            cnt <= 0;
        end else begin
            motionDone <= 1'b0;
            if (reqValid) begin
                held <= req;
            end
            if (startMotion) begin
                running <= 1'b1;
                cnt <= DLY;
                tgt <= held.absMove ? held.value :
                       held.incMove ? commandedPosition + held.value : 32'h0;
            end else if (running) begin
                if (cont && !halted) begin
                    commandedPosition <= commandedPosition + (held.contPos ? 1 : -1);
                    halted <= stopCmd.hardStop | stopCmd.softStop;
                end else if (cnt == 1) begin
                    motionDone <= 1'b1;
                    running <= 1'b0;
                    halted <= 1'b0;
                    if (!cont) begin
                        commandedPosition <= tgt;
                    end
                end else begin
                    cnt <= cnt - 1;
                end
            end
        end
    end
endmodule : motor_driver_model
`default_nettype wire

// *** sim/soft_position_limit_checker_tb.sv ***
// testbench: position limit checker against a behavioural motor driver
`timescale 1ns/1ns
`default_nettype none
module soft_position_limit_checker_tb;
    // -----------------------------------------
    // signals and instances
    // -----------------------------------------
    logic mclk = 1'b0;
    logic sysRst = 1'b1;
    logic savedValid = 1'b0, savedEnable = 1'b0, paramWrite = 1'b0, paramWriteData = 1'b0;
    logic seqRunning = 1'b0, pendingEnable, softLimitEnable, overtravel_stop_action = 1'b0;
    logic signed [31:0] posLim = 32'ha, negLim = -32'sha, cmdPos;
    logic [1:0] alarm_action = 2'h1;
    logic reqValid = 1'b0, motionDone, alarmClear = 1'b0, startMotion, reqRejected, alarm;
    soft_limit_pkg::move_req_s req = '0;
    soft_limit_pkg::stop_cmd_s stopCmd;
    logic [7:0] alarmCode;
    logic [5:0] sigStat;
    int failCount = 0, nTests = 0;
    localparam logic [6:0] kAbs = 7'h40, kInc = 7'h20, kCp = 7'h10, kCn = 7'h08, kHe = 7'h04;
    localparam logic [6:0] kHp = 7'h02;
    always #4 mclk = ~mclk;
    soft_position_limit_checker u_soft_position_limit_checker (.mclk(mclk), .sys_rst(sysRst),
        .savedValid(savedValid), .savedEnable(savedEnable), .paramWrite(paramWrite),
        .paramWriteData(paramWriteData), .seqRunning(seqRunning), .pendingEnable(pendingEnable),
        .softLimitEnable(softLimitEnable), .positivePositionLimit(posLim),
        .negativePositionLimit(negLim), .overtravelStopAction(overtravel_stop_action), .alarmAction(alarm_action),
        .reqValid(reqValid), .req(req), .commandedPosition(cmdPos), .motionDone(motionDone),
        .alarmClear(alarmClear), .startMotion(startMotion), .reqRejected(reqRejected),
        .stopCmd(stopCmd), .alarm(alarm), .alarmCode(alarmCode), .signalStatus(sigStat));
    motor_driver_model u_motor_driver_model (.mclk(mclk), .sys_rst(sysRst), .reqValid(reqValid),
        .req(req), .startMotion(startMotion), .stopCmd(stopCmd), .commandedPosition(cmdPos),
        .motionDone(motionDone));
    // -----------------------------------------
    // shared tasks
    // -----------------------------------------
    task automatic completeRun;
        if (failCount == 0 && nTests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : completeRun
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        nTests++;
        if (got !== exp) begin
            failCount++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task automatic doReset(input logic sv, input logic se);
        @(posedge mclk);
        savedValid <= sv;
        savedEnable <= se;
        sysRst <= 1'b1;
        repeat (12) @(posedge mclk);
        sysRst <= 1'b0;
        tick(2);
    endtask : doReset
    // one request; accept or refusal shows one cycle after it is taken
    task automatic request(input logic [6:0] kind, input logic [31:0] v, input logic ok);
        @(posedge mclk);
        reqValid <= 1'b1;
        req <= {kind, v};
        @(posedge mclk);
        reqValid <= 1'b0;
        #1;
        chk(startMotion, ok, "start");
        chk(reqRejected, !ok, "refuse");
        tick(1);
    endtask : request
    task automatic waitDone;
        int i;
        for (i = 0; i < 300 && motionDone !== 1'b1; i++) tick(1);
        if (i == 300) begin
            failCount++;
            $display("BAD %0t no motion end", $time);
            completeRun();
        end
        tick(2);
    endtask : waitDone
    // continuous move runs until a stop pulse shows
    task automatic waitStop(input logic hard);
        int i;
        for (i = 0; i < 300 && stopCmd.hardStop !== 1'b1 && stopCmd.softStop !== 1'b1; i++) tick(1);
        if (i == 300) begin
            failCount++;
            $display("BAD %0t no stop", $time);
            completeRun();
        end
        chk(stopCmd.hardStop, hard, "hard stop");
        chk(stopCmd.softStop, !hard, "soft stop");
        tick(1);
        chk(sigStat[soft_limit_pkg::SIG_STOP], 1'b1, "stop status");
        waitDone();
    endtask : waitStop
    task automatic clearAlarm;
        @(posedge mclk);
        alarmClear <= 1'b1;
        @(posedge mclk);
        alarmClear <= 1'b0;
        tick(1);
        chk({alarm, stopCmd.currentOff}, 2'h0, "clear");
    endtask : clearAlarm
    // -----------------------------------------
    // scenarios
    // -----------------------------------------
    task automatic scenParam;
        doReset(1'b0, 1'b0);
        chk({softLimitEnable, alarmCode, sigStat}, 15'h0, "reset");
        @(posedge mclk);
        {seqRunning, paramWrite, paramWriteData} <= 3'h7;
        @(posedge mclk);
        {seqRunning, paramWrite} <= 2'h0;
        tick(1);
        chk(pendingEnable, 1'b0, "seq write");
        @(posedge mclk);
        paramWrite <= 1'b1;
        @(posedge mclk);
        paramWrite <= 1'b0;
        tick(1);
        chk({pendingEnable, softLimitEnable}, 2'h2, "write");
        doReset(1'b1, 1'b1); // limits are set before enabling
        chk(softLimitEnable, 1'b1, "saved");
    endtask : scenParam
    task automatic scenHome;
        request(kAbs, 32'h32, 1'b1);
        waitDone();
        request(kHe, 32'h0, 1'b1);
        chk(sigStat[3:2], 2'h1, "home active");
        waitDone();
        chk(sigStat[3:0], 4'ha, "homed");
    endtask : scenHome
    task automatic scenIndex;
        request(kAbs, 32'hb, 1'b0);
        chk({alarm, alarmCode, sigStat[0]}, 10'h2cf, "alarm");
        request(kAbs, 32'h7, 1'b0);
        clearAlarm();
        request(kInc, 32'hb, 1'b0);
        chk(alarm, 1'b0, "inc alarm");
        request(kAbs, 32'ha, 1'b1);
        waitDone();
    endtask : scenIndex
    task automatic scenCont;
        @(posedge mclk);
        overtravel_stop_action <= soft_limit_pkg::OT_SOFT;
        alarm_action <= soft_limit_pkg::ALM_ALARM_OFF;
        request(kCp, 32'h0, 1'b1);
        waitStop(1'b0);
        chk({alarm, stopCmd.currentOff, sigStat[4]}, 3'h7, "curoff");
        clearAlarm();
        @(posedge mclk);
        overtravel_stop_action <= soft_limit_pkg::OT_HARD;
        alarm_action <= soft_limit_pkg::ALM_STOP_ONLY;
        request(kCp, 32'h0, 1'b0);
        request(kCn, 32'h0, 1'b1);
        waitStop(1'b1);
        chk(alarm, 1'b0, "stop only");
    endtask : scenCont
    task automatic scenZero;
        @(posedge mclk);
        posLim <= 32'h0;
        negLim <= 32'h0;
        request(kAbs, 32'h3e8, 1'b1);
        waitDone();
        chk(sigStat[soft_limit_pkg::SIG_ACTIVE], 1'b0, "zero");
        @(posedge mclk);
        posLim <= 32'ha;
        negLim <= 32'h5;
        alarm_action <= soft_limit_pkg::ALM_ALARM;
        request(kHp, 32'h0, 1'b1);
        chk(sigStat[3:2], 2'h1, "rehome active");
        waitDone();
        chk(alarm, 1'b1, "home zero");
    endtask : scenZero
    initial begin
        scenParam();
        scenHome();
        scenIndex();
        scenCont();
        scenZero();
        completeRun();
    end
endmodule : soft_position_limit_checker_tb
`default_nettype wire
